// ### two_wire_bus_buffer_connect_ctrl.sv
/*
  Connection control of a two-wire bus buffer: lockout, join on stop
  or idle, wired-AND of each line pair, stuck-bus timeout and recovery.
  Assumes open-drain pins resolved outside from line_oe, pull-ups on all
  lines, and bus_buffer_pkg compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
`include "bus_buffer_defines.svh"

// How it works
// - enable low isolates pairs, ready low
// - enable rise after stuck fault forces join
// - ready low until connection sequence completes
// - stuck-timeout disconnect drives ready low
// - ready high only when enabled and joined
// - lockout ignores lines except for the idle counters, which keep counting; no stuck monitoring
// - precharge asserted during lockout
// - join on both idle or stop plus idle
// - precharge off at join until next lockout
// - low on one pin pulls its partner
// - pair rises only when all release
// - rising edge releases pull-down, enables accelerator
// - stuck timer per recovery-side line, expiry breaks both pairs
// - wait, up to sixteen clocks, then stop
// - after stuck clears, rejoin on stop/idle
// - enable low suppresses recovery clocking
module two_wire_bus_buffer_connect_ctrl
  import bus_buffer_pkg::*;
#(
  parameter int STUCK_CYCLES = `STUCK_TIMEOUT_US * `CLK_MHZ,
  parameter int WAIT_CYCLES = `RECOVER_WAIT_US * `CLK_MHZ,
  parameter int HALF_CYCLES = (`CLK_MHZ * 1000000) / (2 * `RECOVER_CLK_HZ),
  parameter int IDLE_CYCLES = `IDLE_CYCLES,
  parameter int HOLD_CYCLES = `RELEASE_HOLD_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // bus lines, open drain
  input wire lines_s line_in,
  output var lines_s line_out,
  output var lines_s line_oe,
  // control inputs
  input wire logic enable,
  input wire logic supply_lockout,
  // status outputs
  output logic connection_ready,
  output logic precharge_en,
  output logic [1:0] accel_en
);

  localparam int TW = $clog2(STUCK_CYCLES + 1);
  localparam int PMAX = (WAIT_CYCLES > HALF_CYCLES) ? WAIT_CYCLES : HALF_CYCLES;
  localparam int PW = $clog2(PMAX + 1);
  localparam int IW = $clog2(IDLE_CYCLES + 1);
  localparam int HW = $clog2(HOLD_CYCLES + 1);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // ============================================================
  // input synchronisers, three stages, change when stages 2 and 3 agree
  logic [`SYNC_W-1:0] sync1, sync2, sync3, filt, next_filt;
  logic [3:0] lines_f, lines_prev;
  logic enable_f, enable_prev, lockout_f;

  always_comb begin
    next_filt = filt;
    for (int i = 0; i < `SYNC_W; i++) begin
      if (sync2[i] == sync3[i]) begin
        next_filt[i] = sync3[i];
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1 <= `SYNC_RESET;
      sync2 <= `SYNC_RESET;
      sync3 <= `SYNC_RESET;
      filt <= `SYNC_RESET;
      lines_prev <= 4'hf;
      enable_prev <= 1'b0;
    end else begin
      sync1 <= {supply_lockout, enable, line_in};
      sync2 <= sync1;
      sync3 <= sync2;
      filt <= next_filt;
      lines_prev <= lines_f;
      enable_prev <= enable_f;
    end
  end

  assign lines_f = filt[3:0];
  assign enable_f = filt[`SYNC_ENABLE];
  assign lockout_f = filt[`SYNC_LOCKOUT];

  // ============================================================
  // segment monitors: stop and idle per segment (0 protected, 1 recovery)
  conn_state_e state, next_state;
  wire [1:0] seg_stop, seg_idle, stuck_exp;
  logic timer_clr;

  for (genvar s = 0; s < 2; s++) begin : g_seg
    logic [IW-1:0] idle_cnt, next_idle_cnt;
    always_comb begin
      if (lines_f[2*s] && lines_f[2*s+1]) begin
        next_idle_cnt = (idle_cnt == IW'(IDLE_CYCLES)) ? idle_cnt
                                                        : idle_cnt + 1'b1;
      end else begin
        next_idle_cnt = '0;
      end
    end
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        idle_cnt <= '0;
      end else begin
        idle_cnt <= next_idle_cnt;
      end
    end
    assign seg_idle[s] = (idle_cnt == IW'(IDLE_CYCLES));
    // data rising while clock stays high
    assign seg_stop[s] = lines_f[2*s] && !lines_prev[2*s]
                         && lines_f[2*s+1] && lines_prev[2*s+1];
  end

  // ============================================================
  // stuck timers, one per recovery-side line
  for (genvar r = 0; r < 2; r++) begin : g_stuck
    logic [TW-1:0] stk_cnt, next_stk_cnt;
    always_comb begin
      if (lines_f[`IDX_REC_DATA+r] || timer_clr) begin
        next_stk_cnt = '0;
      end else if ((state == monitor || state == joined)
                   && stk_cnt != TW'(STUCK_CYCLES)) begin
        next_stk_cnt = stk_cnt + 1'b1;
      end else begin
        next_stk_cnt = stk_cnt;
      end
    end
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        stk_cnt <= '0;
      end else begin
        stk_cnt <= next_stk_cnt;
      end
    end
    assign stuck_exp[r] = (stk_cnt == TW'(STUCK_CYCLES));
  end

  // ============================================================
  // wired-AND per pair (0 data, 1 clock) while joined
  wire [1:0] next_drv_rec, next_drv_prot, next_accel;

  for (genvar p = 0; p < 2; p++) begin : g_pair
    logic drv_rec, drv_prot, nd_rec, nd_prot;
    logic [HW-1:0] hold, next_hold;
    logic prot_l, rec_l;
    assign prot_l = lines_f[p];
    assign rec_l = lines_f[p+2];
    always_comb begin
      nd_rec = drv_rec;
      nd_prot = drv_prot;
      next_hold = hold;
      if (state != joined || next_state != joined) begin
        nd_rec = 1'b0;
        nd_prot = 1'b0;
        next_hold = '0;
      end else if (hold != '0) begin
        next_hold = hold - 1'b1; // own release still echoing back
      end else if (drv_rec) begin
        if (prot_l) begin
          nd_rec = 1'b0;
          next_hold = HW'(HOLD_CYCLES);
        end
      end else if (drv_prot) begin
        if (rec_l) begin
          nd_prot = 1'b0;
          next_hold = HW'(HOLD_CYCLES);
        end
      end else if (!prot_l) begin
        nd_rec = 1'b1;
      end else if (!rec_l) begin
        nd_prot = 1'b1;
      end
    end
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        drv_rec <= 1'b0;
        drv_prot <= 1'b0;
        hold <= '0;
      end else begin
        drv_rec <= nd_rec;
        drv_prot <= nd_prot;
        hold <= next_hold;
      end
    end
    // pull-down held until the originating side rises
    assign next_drv_rec[p] = nd_rec;
    assign next_drv_prot[p] = nd_prot;
    assign next_accel[p] = (next_hold != '0);
  end

  // ============================================================
  // connection state machine and recovery sequencer
  logic [PW-1:0] phase, next_phase;
  logic half, next_half, fault, next_fault;
  logic [4:0] pulses, next_pulses;
  logic join_ok, force_join, en_rise;

  assign en_rise = enable_f && !enable_prev;
  assign force_join = fault && en_rise;
  assign join_ok = enable_f && ((seg_idle[0] && seg_idle[1])
                   || (seg_stop[0] && seg_idle[1])
                   || (seg_stop[1] && seg_idle[0]));

  always_comb begin
    next_state = state;
    next_phase = phase;
    next_half = half;
    next_pulses = pulses;
    next_fault = fault;
    timer_clr = 1'b0;
    if (lockout_f) begin
      next_state = lockout;
      next_fault = 1'b0;
      timer_clr = 1'b1;
    end else if (force_join && state != joined) begin
      next_state = joined;
      next_fault = 1'b0;
      timer_clr = 1'b1;
    end else begin
      unique case (state)
        lockout: next_state = monitor;
        monitor, joined: begin
          if (|stuck_exp) begin
            next_state = stuck_wait;
            next_fault = 1'b1;
            next_phase = '0;
          end else if (state == monitor && join_ok) begin
            next_state = joined;
          end else if (state == joined && !enable_f) begin
            next_state = monitor;
          end
        end
        stuck_wait: begin
          if (!enable_f) begin
            next_state = recovered;
          end else if (phase == PW'(WAIT_CYCLES - 1)) begin
            next_state = recover_clk;
            next_phase = '0;
            next_half = 1'b1;
            next_pulses = '0;
          end else begin
            next_phase = phase + 1'b1;
          end
        end
        recover_clk: begin
          if (!enable_f) begin
            next_state = recovered;
          end else if (phase != PW'(HALF_CYCLES - 1)) begin
            next_phase = phase + 1'b1;
          end else begin
            next_phase = '0;
            next_half = !half;
            if (!half) begin // end of one whole pulse
              next_pulses = pulses + 1'b1;
              next_half = 1'b1;
              if (pulses == 5'(`RECOVER_PULSES - 1)
                  || (lines_f[`IDX_REC_DATA] && lines_f[`IDX_REC_CLK])) begin
                next_state = recover_stop;
              end
            end
          end
        end
        recover_stop: begin
          if (phase != PW'(HALF_CYCLES - 1)) begin
            next_phase = phase + 1'b1;
          end else begin
            next_phase = '0;
            next_half = 1'b0;
            if (!half) begin
              next_state = recovered;
            end
          end
        end
        recovered: begin
          if (lines_f[`IDX_REC_DATA] && lines_f[`IDX_REC_CLK]) begin
            next_state = monitor;
          end
        end
        default: next_state = lockout;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= lockout;
      phase <= '0;
      half <= 1'b0;
      pulses <= '0;
      fault <= 1'b0;
    end else begin
      state <= next_state;
      phase <= next_phase;
      half <= next_half;
      pulses <= next_pulses;
      fault <= next_fault;
    end
  end

  // ============================================================
  // output registers
  logic next_ready, next_precharge;
  lines_s next_oe;

  always_comb begin
    next_ready = (next_state == joined) && enable_f;
    if (lockout_f) begin
      next_precharge = 1'b1;
    end else if (next_state == joined) begin
      next_precharge = 1'b0;
    end else begin
      next_precharge = precharge_en;
    end
    next_oe = lines_s'({next_drv_rec, next_drv_prot});
    if (next_state == recover_clk && next_half) begin
      next_oe.recovery_side_clock_line = 1'b1;
    end
    if (next_state == recover_stop && next_half) begin
      next_oe.recovery_side_data_line = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      connection_ready <= 1'b0;
      precharge_en <= 1'b1;
      accel_en <= 2'h0;
      line_oe <= '0;
      line_out <= '0;
    end else begin
      connection_ready <= next_ready;
      precharge_en <= next_precharge;
      accel_en <= next_accel;
      line_oe <= next_oe;
      line_out <= '0;
    end
  end

  // ============================================================
  // checks
  sequence s_rec_driven;
    g_pair[0].drv_rec && state == joined && next_state == joined;
  endsequence
  sequence s_prot_rises;
    lines_f[`IDX_PROT_DATA] && g_pair[0].hold == '0;
  endsequence

  ready_enable_a: assert property (!enable_f |=> !connection_ready)
    else $error("ready high while enable low");
  force_join_a: assert property (
    force_join && !lockout_f |=> state == joined && connection_ready)
    else $error("enable rise after fault did not join");
  ready_stuck_a: assert property (
    state == joined && |stuck_exp && !lockout_f && !force_join
    |=> state == stuck_wait && !connection_ready)
    else $error("stuck timeout left ready high");
  ready_joined_a: assert property (
    connection_ready |-> state == joined && $past(enable_f))
    else $error("ready high while not joined");
  precharge_on_a: assert property (lockout_f |=> precharge_en)
    else $error("precharge off during lockout");
  precharge_off_a: assert property (
    !precharge_en && !lockout_f |=> !precharge_en)
    else $error("precharge returned without lockout");
  join_cond_a: assert property (
    state == monitor && !join_ok && !force_join |=> state != joined)
    else $error("joined without stop or idle");
  release_accel_a: assert property (
    s_rec_driven ##0 s_prot_rises
    |=> !line_oe.recovery_side_data_line && accel_en[0])
    else $error("rising edge did not release and accelerate");
  pulse_limit_a: assert property (
    state == recover_clk |-> pulses < 5'(`RECOVER_PULSES))
    else $error("too many recovery pulses");
  no_clock_disabled_a: assert property (
    !enable_f && state != recover_clk |=> state != recover_clk)
    else $error("recovery clocking with enable low");

endmodule : two_wire_bus_buffer_connect_ctrl

`default_nettype wire

// ### bus_buffer_defines.svh
/*
  Constants of the two-wire bus buffer connection control: clock rate,
  recovery timings, line indices and synchroniser reset pattern.
  Assumes inclusion by bare name from the package and the design file.
*/
`ifndef BUS_BUFFER_DEFINES_SVH
`define BUS_BUFFER_DEFINES_SVH

// ============================================================
// timing
`define CLK_MHZ 250
`define STUCK_TIMEOUT_US 30000
`define RECOVER_WAIT_US 40
`define RECOVER_CLK_HZ 8500
`define RECOVER_PULSES 16
`define IDLE_CYCLES 64
`define RELEASE_HOLD_CYCLES 8

// ============================================================
// line indices inside the packed line group
`define IDX_PROT_DATA 0
`define IDX_PROT_CLK 1
`define IDX_REC_DATA 2
`define IDX_REC_CLK 3

// ============================================================
// synchroniser layout: {lockout, enable, lines}
`define SYNC_W 6
`define SYNC_ENABLE 4
`define SYNC_LOCKOUT 5
`define SYNC_RESET 6'h2f

`endif

// ### bus_buffer_pkg.sv
/*
  Types of the two-wire bus buffer connection control.
  Assumes bus_buffer_defines.svh sits in the same folder.
*/
`default_nettype none
`include "bus_buffer_defines.svh"

package bus_buffer_pkg;

  // ============================================================
  // the four bus lines, bit 0 is the protected data line
  typedef struct packed {
    logic recovery_side_clock_line;
    logic recovery_side_data_line;
    logic protected_side_clock_line;
    logic protected_side_data_line;
  } lines_s;

  // ============================================================
  // connection states, gray along the usual path
  typedef enum logic [2:0] {
    lockout = 3'h0,
    monitor = 3'h1,
    joined = 3'h3,
    stuck_wait = 3'h2,
    recover_clk = 3'h6,
    recover_stop = 3'h7,
    recovered = 3'h5
  } conn_state_e;

endpackage : bus_buffer_pkg

`default_nettype wire

// ### bus_pair_model.sv
/*
  Model of the two bus segments around the buffer: pull-ups on all four
  lines, bench-held lows and a short protected-side transfer burst.
  Assumes bus_buffer_pkg is compiled first and the device pulls low
  wherever its line_oe bit is high.
*/
`timescale 1ns/1ns
`default_nettype none

module bus_pair_model
  import bus_buffer_pkg::*;
(
  // requests from the bench
  input wire lines_s hold,
  input wire logic burst_go,
  // device pull-downs and resolved pin levels
  input wire lines_s line_oe,
  output var lines_s line_in,
  output logic burst_busy
);
  logic burst_data_low;
  logic burst_clk_low;
  logic [3:0] low;

  // ============================================================
  // wired-AND with pull-ups: any party pulling low wins
  always_comb begin
    low = hold | line_oe | {2'b00, burst_clk_low, burst_data_low};
    line_in = lines_s'(~low);
  end

  // ============================================================
  // start, four clocks at 125 ns, stop; clock idle high between frames
  initial begin
    burst_busy = 1'b0;
    burst_data_low = 1'b0;
    burst_clk_low = 1'b0;
  end

  always @(posedge burst_go) begin
    burst_busy = 1'b1;
    burst_data_low = 1'b1;
    #62;
    repeat (4) begin
      burst_clk_low = 1'b1;
      #63;
      burst_clk_low = 1'b0;
      #62;
    end
    #31;
    burst_data_low = 1'b0;
    #31;
    burst_busy = 1'b0;
  end

endmodule : bus_pair_model

`default_nettype wire

// ### tb_two_wire_bus_buffer_connect_ctrl.sv
/*
  Self-checking bench of the bus buffer connection control: lockout,
  join, wired-AND, stuck timeout, recovery, forced join and stop join.
  Assumes the design, its package and bus_pair_model are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none

module tb_two_wire_bus_buffer_connect_ctrl
  import bus_buffer_pkg::*;
;
  logic clk;
  logic reset_n;
  logic enable;
  logic supply_lockout;
  logic burst_go;
  lines_s hold;
  lines_s line_in;
  lines_s line_oe;
  lines_s line_out;
  logic connection_ready;
  logic precharge_en;
  logic [1:0] accel_en;
  logic burst_busy;
  logic [3:0] oe_v;
  int errors;
  int checks;
  int idx;
  int n_clk;
  int n_dat;

  assign oe_v = line_oe;

  // ============================================================
  // clock and instances
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  two_wire_bus_buffer_connect_ctrl #(
    .STUCK_CYCLES(200), .WAIT_CYCLES(10), .HALF_CYCLES(8),
    .IDLE_CYCLES(64), .HOLD_CYCLES(8)
  ) uut (
    .clk(clk), .reset_n(reset_n), .line_in(line_in),
    .line_out(line_out), .line_oe(line_oe), .enable(enable),
    .supply_lockout(supply_lockout), .connection_ready(connection_ready),
    .precharge_en(precharge_en), .accel_en(accel_en)
  );

  bus_pair_model partner (
    .hold(hold), .burst_go(burst_go), .line_oe(line_oe),
    .line_in(line_in), .burst_busy(burst_busy)
  );

  // ============================================================
  // helpers
  // the opposite pin of the same pair
  function automatic logic [3:0] mirror_of(input int i);
    return 4'h1 << (i ^ 2);
  endfunction : mirror_of

  task automatic check(input logic [3:0] seen, input logic [3:0] exp,
                       input string what);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t %s seen %h expected %h", $time, what,
               seen, exp);
    end
  endtask : check

  task automatic wait_ready(input logic val, input int lim);
    for (int n = 0; n < lim && connection_ready !== val; n++)
      @(negedge clk);
    check({3'h0, connection_ready}, {3'h0, val}, "ready");
  endtask : wait_ready

  // counts device pulses on the recovery clock and data lines
  task automatic count_rises(input int cycles, output int nc,
                             output int nd);
    logic [3:0] prev;
    prev = oe_v;
    nc = 0;
    nd = 0;
    repeat (cycles) begin
      @(negedge clk);
      if (oe_v[3] === 1'b1 && prev[3] !== 1'b1) nc++;
      if (oe_v[2] === 1'b1 && prev[2] !== 1'b1) nd++;
      prev = oe_v;
    end
  endtask : count_rises

  task automatic close_out;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out

  // ============================================================
  // watchdog, well beyond the expected run of about 8 us
  initial begin
    #200000;
    errors++;
    close_out();
  end

  // ============================================================
  // main sequence, inputs change at the falling edge
  initial begin
    reset_n = 1'b0;
    enable = 1'b0;
    supply_lockout = 1'b1;
    burst_go = 1'b0;
    hold = '0;
    errors = 0;
    checks = 0;
    void'($urandom(32'h899de632));
    repeat (10) @(negedge clk);
    reset_n = 1'b1;
    // lockout: line activity ignored, precharge on, ready low
    enable = 1'b1;
    repeat (100) begin
      @(negedge clk);
      hold = lines_s'($urandom_range(15, 0));
      check(oe_v, 4'h0, "lockout oe");
      check({3'h0, precharge_en}, 4'h1, "precharge");
      check({3'h0, connection_ready}, 4'h0, "ready early");
    end
    hold = '0;
    // leave lockout, both segments idle
    supply_lockout = 1'b0;
    wait_ready(1'b1, 120);
    check({3'h0, precharge_en}, 4'h0, "precharge at join");
    // wired-AND on random lines
    repeat (8) begin
      idx = $urandom_range(3, 0);
      hold = lines_s'(4'h1 << idx);
      repeat (8) @(negedge clk);
      check(oe_v, mirror_of(idx), "pull opposite");
      repeat ($urandom_range(20, 2)) @(negedge clk);
      check(oe_v, mirror_of(idx), "held while low");
      hold = '0;
      for (int n = 0; n < 12 && oe_v !== 4'h0; n++) @(negedge clk);
      check(oe_v, 4'h0, "release");
      check(line_out, 4'h0, "open drain level");
      check({3'h0, accel_en[idx & 1]}, 4'h1, "accel");
      repeat (16) @(negedge clk);
    end
    // enable low isolates
    enable = 1'b0;
    wait_ready(1'b0, 8);
    hold.protected_side_data_line = 1'b1;
    repeat (10) @(negedge clk);
    check(oe_v, 4'h0, "isolated");
    hold = '0;
    enable = 1'b1;
    wait_ready(1'b1, 120);
    // stuck recovery data line
    hold.recovery_side_data_line = 1'b1;
    wait_ready(1'b0, 260);
    check(oe_v & 4'h1, 4'h0, "pairs broken");
    count_rises(500, n_clk, n_dat);
    check(n_clk[3:0], 4'h0, "sixteen pulses");
    check({3'h0, n_clk == 16}, 4'h1, "pulse count");
    check({3'h0, n_dat != 0}, 4'h1, "stop driven");
    check({3'h0, precharge_en}, 4'h0, "precharge stays off");
    // forced join on an enable rising edge while still stuck
    enable = 1'b0;
    repeat (8) @(negedge clk);
    enable = 1'b1;
    wait_ready(1'b1, 10);
    hold = '0;
    repeat (20) @(negedge clk);
    // stuck with enable low: no recovery clocking
    enable = 1'b0;
    wait_ready(1'b0, 8);
    hold.recovery_side_clock_line = 1'b1;
    count_rises(500, n_clk, n_dat);
    check(n_clk[3:0], 4'h0, "no clocking");
    hold = '0;
    repeat (20) @(negedge clk);
    // lockout recurs, then join on a stop after a transfer
    supply_lockout = 1'b1;
    repeat (8) @(negedge clk);
    check({3'h0, precharge_en}, 4'h1, "precharge again");
    supply_lockout = 1'b0;
    enable = 1'b1;
    burst_go = 1'b1;
    repeat (100) @(negedge clk);
    check({3'h0, connection_ready}, 4'h0, "no join mid frame");
    for (int n = 0; n < 200 && burst_busy !== 1'b0; n++) @(negedge clk);
    wait_ready(1'b1, 20);
    burst_go = 1'b0;
    repeat (10) @(negedge clk);
    close_out();
  end

endmodule : tb_two_wire_bus_buffer_connect_ctrl

`default_nettype wire
